// file: logic/smic_top.sv
// Supply monitor and primary interrupt controller top level.
//
// Overview of operation
// - Low-supply flag is high while supply is below selected threshold.
// - In sleep the monitor is frozen, even when enabled.
// - Supply-drop request flag sets only after the interrupt delay.
// - Supply-drop request flag set ends idle mode.
// - A serviced enabled interrupt suspends the main program.
// - Requests come from four pins and internal sources.
// - Two-bit edge code: off, rising, falling, both.
// - Edge-select fields pin3 bits 7:6 down to pin0 bits 1:0.
// - Control A bit 0 is the global interrupt enable.
// - Each source has its own request flag and enable bit.
// - Control A holds group 0 and pin flags 6..4, enables 3..1.
// - Timer comparator requests combine into two group flags.
// - Monitor control holds read-only flag bit 5, enable bit 4.
// - Threshold select bits 2:0, 000 lowest up to 110.
// - Control D holds supply-drop flag bit 4, enable bit 0.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "smic_consts.svh"
module smic_top (
    input  wire logic                 sys_clk_i,
    input  wire logic                 reset_n_i,
    input  wire smic_pkg::smic_bus_req_t bus_i,
    input  wire smic_pkg::smic_sense_t   sense_i,
    input  wire logic [3:0]           tm_src_i,
    input  wire logic [3:0]           tm2_src_i,
    input  wire logic                 tb0_src_i,
    input  wire logic                 tb1_src_i,
    input  wire logic                 ee_src_i,
    input  wire logic                 adc_src_i,
    input  wire logic                 uart_src_i,
    input  wire logic                 sim_src_i,
    input  wire logic                 irq_ack_i,
    output logic [7:0]                rdata_o,
    output logic                      irq_req_o,
    output logic                      suspend_o,
    output logic                      sleep_o,
    output logic                      idle_o
);
    import smic_pkg::*;

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] mon_q;
    logic [7:0] edge_q;
    logic [7:0] ca_q;
    logic [7:0] cb_q;
    logic [7:0] cc_q;
    logic [7:0] cd_q;
    logic [7:0] ga_q;
    logic [7:0] gb_q;
    logic [1:0] mode_q;
    logic [7:0] rdata_q;
    logic       irq_q;
    logic       susp_q;

    logic [3:0] pin_hit;
    logic       mon_flag;
    logic       mon_irq;

    // The request is an argument so that continuous users see every change.
    function automatic logic wr_at(input smic_bus_req_t b,
                                   input logic [3:0]    a);
        wr_at = b.wr && (b.addr == a);
    endfunction : wr_at

    // Flag update: set wins over a software write of 0.
    function automatic logic [7:0] flag_upd(input logic [7:0] cur,
                                            input logic       wr,
                                            input logic [7:0] wd,
                                            input logic [7:0] hw);
        flag_upd = (wr ? wd : cur) | hw;
    endfunction : flag_upd

    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------
    smic_edge_det u_edge (
        .sys_clk_i  (sys_clk_i),
        .reset_n_i  (reset_n_i),
        .pins_i     (sense_i.pins),
        .edge_sel_i (edge_q),
        .hit_o      (pin_hit)
    );

    smic_supply_mon u_mon (
        .sys_clk_i  (sys_clk_i),
        .reset_n_i  (reset_n_i),
        .enable_i   (mon_q[`SMIC_MON_EN_BIT]),
        .sleep_i    (mode_q[`SMIC_MODE_SLEEP_BIT]),
        .thresh_i   (mon_q[2:0]),
        .below_i    (sense_i.below),
        .flag_o     (mon_flag),
        .irq_o      (mon_irq)
    );

    // ------------------------------------------------------------------
    // Hardware set terms
    // ------------------------------------------------------------------
    // group request combine
    wire g0_any = |(ga_q[7:4] & ga_q[3:0]);
    wire g1_any = |(gb_q[7:4] & gb_q[3:0]);
    wire [7:0] ca_hw = {1'b0, g0_any, pin_hit[1], pin_hit[0], 4'h0};
    wire [7:0] cb_hw = {pin_hit[2], uart_src_i, sim_src_i, g1_any, 4'h0};
    wire [7:0] cc_hw = {adc_src_i, tb1_src_i, tb0_src_i, pin_hit[3], 4'h0};
    wire [7:0] cd_hw = {2'b00, ee_src_i, mon_irq, 4'h0};
    wire [7:0] ga_hw = {tm_src_i, 4'h0};
    wire [7:0] gb_hw = {tm2_src_i, 4'h0};

    wire [7:0] ca_d = flag_upd(ca_q, wr_at(bus_i, `SMIC_ADDR_CTRL_A),
                               bus_i.wdata, ca_hw) & `SMIC_A_RW_MASK;
    wire [7:0] cb_d = flag_upd(cb_q, wr_at(bus_i, `SMIC_ADDR_CTRL_B),
                               bus_i.wdata, cb_hw);
    wire [7:0] cc_d = flag_upd(cc_q, wr_at(bus_i, `SMIC_ADDR_CTRL_C),
                               bus_i.wdata, cc_hw);
    wire [7:0] cd_d = flag_upd(cd_q, wr_at(bus_i, `SMIC_ADDR_CTRL_D),
                               bus_i.wdata, cd_hw) & `SMIC_D_RW_MASK;
    wire [7:0] ga_d = flag_upd(ga_q, wr_at(bus_i, `SMIC_ADDR_GROUP_A),
                               bus_i.wdata, ga_hw);
    wire [7:0] gb_d = flag_upd(gb_q, wr_at(bus_i, `SMIC_ADDR_GROUP_B),
                               bus_i.wdata, gb_hw);

    // ------------------------------------------------------------------
    // Request forwarding
    // ------------------------------------------------------------------
    // flag and enable pairs
    wire [3:0] a_p = {ca_q[6:4], 1'b0} & {ca_q[3:1], 1'b0};
    wire [3:0] b_p = cb_q[7:4] & cb_q[3:0];
    wire [3:0] c_p = cc_q[7:4] & cc_q[3:0];
    wire [3:0] d_p = cd_q[7:4] & cd_q[3:0];
    wire       req_d = ca_q[`SMIC_A_GIE_BIT] & |{a_p, b_p, c_p, d_p};

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    // monitor flag read-only
    wire [7:0] mon_rd = (mon_q & `SMIC_MON_RW_MASK)
                      | ({7'h00, mon_flag} << `SMIC_MON_FLAG_BIT);
    logic [7:0] rd_sel;
    always_comb begin
        rd_sel = 8'h00;
        case (bus_i.addr)
            `SMIC_ADDR_MONITOR_CTRL: rd_sel = mon_rd;
            `SMIC_ADDR_EDGE_SEL:     rd_sel = edge_q;
            `SMIC_ADDR_CTRL_A:       rd_sel = ca_q;
            `SMIC_ADDR_CTRL_B:       rd_sel = cb_q;
            `SMIC_ADDR_CTRL_C:       rd_sel = cc_q;
            `SMIC_ADDR_CTRL_D:       rd_sel = cd_q;
            `SMIC_ADDR_GROUP_A:      rd_sel = ga_q;
            `SMIC_ADDR_GROUP_B:      rd_sel = gb_q;
            `SMIC_ADDR_MODE:         rd_sel = {6'h00, mode_q};
            default:                 rd_sel = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mon_q <= `SMIC_RESET_BYTE;
            edge_q <= `SMIC_RESET_BYTE;
            ca_q  <= `SMIC_RESET_BYTE;
            cb_q  <= `SMIC_RESET_BYTE;
            cc_q  <= `SMIC_RESET_BYTE;
            cd_q  <= `SMIC_RESET_BYTE;
            ga_q  <= `SMIC_RESET_BYTE;
            gb_q  <= `SMIC_RESET_BYTE;
        end else begin
            if (wr_at(bus_i, `SMIC_ADDR_MONITOR_CTRL)) begin
                mon_q <= bus_i.wdata & `SMIC_MON_RW_MASK;
            end
            if (wr_at(bus_i, `SMIC_ADDR_EDGE_SEL)) begin
                edge_q <= bus_i.wdata;
            end
            ca_q <= ca_d;
            cb_q <= cb_d;
            cc_q <= cc_d;
            cd_q <= cd_d;
            ga_q <= ga_d;
            gb_q <= gb_d;
        end
    end

    // Mode bits model the core's power state. A newly set supply-drop flag clears idle.
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q <= 2'b00;
        end else if (cd_d[`SMIC_D_LVF_BIT] && !cd_q[`SMIC_D_LVF_BIT]) begin
            mode_q[`SMIC_MODE_IDLE_BIT] <= 1'b0;
        end else if (wr_at(bus_i, `SMIC_ADDR_MODE)) begin
            mode_q <= bus_i.wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 8'h00;
            irq_q   <= 1'b0;
            susp_q  <= 1'b0;
        end else begin
            rdata_q <= bus_i.rd ? rd_sel : 8'h00;
            irq_q   <= req_d;
            if (req_d && irq_ack_i) begin
                susp_q <= 1'b1;
            end else if (!req_d) begin
                susp_q <= 1'b0;
            end
        end
    end

    assign rdata_o   = rdata_q;
    assign irq_req_o = irq_q;
    assign suspend_o = susp_q;
    assign sleep_o   = mode_q[`SMIC_MODE_SLEEP_BIT];
    assign idle_o    = mode_q[`SMIC_MODE_IDLE_BIT];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_rd_issue;
        bus_i.rd;
    endsequence

    AST_FWD_GATE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        irq_req_o |-> $past(ca_q[0]))
        else $error("Request forwarded without global enable.");
    AST_GIE_OFF: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        !ca_q[0] |=> !irq_req_o)
        else $error("Request seen while global enable low.");
    AST_FLAG_HOLD: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        (cd_q[4] && !wr_at(bus_i, `SMIC_ADDR_CTRL_D)) |=> cd_q[4])
        else $error("Supply-drop flag lost without a write.");
    AST_PIN_SET: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        pin_hit[0] |=> ca_q[4])
        else $error("Pin 0 flag missed after edge.");
    AST_EDGE_OFF: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        (edge_q[1:0] == 2'b00) |-> !pin_hit[0])
        else $error("Disabled pin produced an edge.");
    AST_LVF_DELAY: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        mon_irq |-> mon_flag && $past(mon_flag))
        else $error("Supply-drop request without a prior low flag.");
    AST_WAKE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(cd_q[4]) && !$past(wr_at(bus_i, `SMIC_ADDR_MODE))
        |-> !idle_o)
        else $error("Idle not left on supply-drop request.");
    AST_SLEEP_FREEZE: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        (sleep_o && mon_q[4]) |=> $stable(mon_flag))
        else $error("Monitor flag moved during sleep.");
    AST_RD_DATA: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_rd_issue ##0 (bus_i.addr == `SMIC_ADDR_EDGE_SEL)
        |=> rdata_o == $past(edge_q))
        else $error("Edge-select readback wrong.");
    AST_SUSPEND: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        suspend_o |-> irq_req_o)
        else $error("Suspend seen without a pending request.");
    AST_LVF_SET: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        mon_irq |=> cd_q[`SMIC_D_LVF_BIT])
        else $error("Supply-drop flag not set after delayed request.");

endmodule : smic_top
`default_nettype wire

// file: logic/smic_consts.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SMIC_CONSTS_SVH
`define SMIC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SMIC_ADDR_MONITOR_CTRL 4'h0
`define SMIC_ADDR_EDGE_SEL     4'h1
`define SMIC_ADDR_CTRL_A       4'h2
`define SMIC_ADDR_CTRL_B       4'h3
`define SMIC_ADDR_CTRL_C       4'h4
`define SMIC_ADDR_CTRL_D       4'h5
`define SMIC_ADDR_GROUP_A      4'h6
`define SMIC_ADDR_GROUP_B      4'h7
`define SMIC_ADDR_MODE         4'h8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SMIC_MON_FLAG_BIT      5
`define SMIC_MON_EN_BIT        4
`define SMIC_MON_RW_MASK       8'h17
`define SMIC_A_GIE_BIT         0
`define SMIC_A_RW_MASK         8'h7F
`define SMIC_D_LVF_BIT         4
`define SMIC_D_LVE_BIT         0
`define SMIC_D_RW_MASK         8'h33
`define SMIC_MODE_SLEEP_BIT    0
`define SMIC_MODE_IDLE_BIT     1

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define SMIC_RESET_BYTE        8'h00
`define SMIC_CLK_MHZ           20
`define SMIC_IRQ_DELAY_US      100
`define SMIC_IRQ_DELAY_CYC     (`SMIC_IRQ_DELAY_US * `SMIC_CLK_MHZ)

`endif

// file: logic/smic_pkg.sv
// Types shared by the supply monitor and interrupt controller.
package smic_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } smic_bus_req_t;

    typedef struct packed {
        logic [3:0] pins;
        logic [6:0] below;
    } smic_sense_t;

    typedef enum logic [2:0] {
        SMIC_MON_OFF  = 3'b001,
        SMIC_MON_WAIT = 3'b010,
        SMIC_MON_LOW  = 3'b100
    } smic_mon_state_t;

endpackage : smic_pkg

// file: logic/smic_edge_det.sv
// Edge detector for the four external interrupt pins.
`timescale 1ns/100ps
`default_nettype none
module smic_edge_det (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [3:0] pins_i,
    input  wire logic [7:0] edge_sel_i,
    output logic      [3:0] hit_o
);
    import smic_pkg::*;

    logic [3:0] prev_q;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev_q <= 4'h0;
        end else begin
            prev_q <= pins_i;
        end
    end

    // ------------------------------------------------------------------
    // Per-pin edge qualification
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pin
            wire rise = pins_i[g] & ~prev_q[g];
            wire fall = ~pins_i[g] & prev_q[g];
            assign hit_o[g] = (edge_sel_i[2*g] & rise)
                            | (edge_sel_i[2*g+1] & fall);
        end
    endgenerate

endmodule : smic_edge_det
`default_nettype wire

// file: logic/smic_supply_mon.sv
// Supply comparator and delayed supply-drop request timer.
`timescale 1ns/100ps
`default_nettype none
`include "smic_consts.svh"
module smic_supply_mon (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       enable_i,
    input  wire logic       sleep_i,
    input  wire logic [2:0] thresh_i,
    input  wire logic [6:0] below_i,
    output logic            flag_o,
    output logic            irq_o
);
    import smic_pkg::*;

    localparam int unsigned DLY = `SMIC_IRQ_DELAY_CYC;

    smic_mon_state_t state_q;
    smic_mon_state_t state_d;
    logic [15:0]     cnt_q;
    logic            flag_q;
    wire             active = enable_i & ~sleep_i;
    // Code 111 has no level; the monitor then never reports low.
    wire             low = (thresh_i == 3'h7) ? 1'b0 : below_i[thresh_i];

    // ------------------------------------------------------------------
    // Comparator flag
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flag_q <= 1'b0;
        end else if (enable_i && !sleep_i) begin
            flag_q <= low;
        end else if (!enable_i) begin
            flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Delay timer
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            SMIC_MON_OFF: begin
                if (active && flag_q) begin
                    state_d = SMIC_MON_WAIT;
                end
            end
            SMIC_MON_WAIT: begin
                if (!active || !flag_q) begin
                    state_d = SMIC_MON_OFF;
                end else if (cnt_q == 16'(DLY - 1)) begin
                    state_d = SMIC_MON_LOW;
                end
            end
            SMIC_MON_LOW: begin
                if (!flag_q) begin
                    state_d = SMIC_MON_OFF;
                end
            end
            default: state_d = SMIC_MON_OFF;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= SMIC_MON_OFF;
            cnt_q   <= 16'h0000;
        end else begin
            state_q <= state_d;
            cnt_q   <= (state_q == SMIC_MON_WAIT) ? cnt_q + 16'h0001
                                                  : 16'h0000;
        end
    end

    assign flag_o = flag_q;
    assign irq_o  = (state_q == SMIC_MON_WAIT) && (state_d == SMIC_MON_LOW);

endmodule : smic_supply_mon
`default_nettype wire

// file: tb/smic_core_model.sv
// Behavioural processor core that accepts interrupt requests.
`timescale 1ns/100ps
`default_nettype none
module smic_core_model (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       irq_req_i,
    input  wire logic [3:0] delay_i,
    output logic            irq_ack_o
);
    // ------------------------------------------------------------------
    // Acceptance
    // ------------------------------------------------------------------
    logic [3:0] wait_q;

    // accept only a forwarded request.
    // A slow core is modelled by a longer delay before the acknowledge.
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_q    <= 4'h0;
            irq_ack_o <= 1'b0;
        end else if (!irq_req_i) begin
            wait_q    <= 4'h0;
            irq_ack_o <= 1'b0;
        end else if (wait_q >= delay_i) begin
            irq_ack_o <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : smic_core_model
`default_nettype wire

// file: tb/tb_supply_monitor_and_irq_control.sv
// Self-checking bench for the supply monitor and interrupt controller.
`timescale 1ns/100ps
`default_nettype none
module tb_supply_monitor_and_irq_control;
    import smic_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } smic_row_t;
    smic_bus_req_t bus;
    smic_sense_t   sense;
    logic          sys_clk;
    logic          reset_n;
    logic [7:0]    srcv;
    logic [7:0]    rdata;
    logic          irq_req;
    logic          ack;
    logic          suspend;
    logic          sleep;
    logic          idle;
    logic [3:0]    dly;
    int            failures;
    int            n_tests;
    int            cyc = 0;
    smic_row_t     rows [11];
    smic_row_t     srcs [8];
    smic_row_t     pins [4];

    smic_top dut (
        .sys_clk_i  (sys_clk),
        .reset_n_i  (reset_n),
        .bus_i      (bus),
        .sense_i    (sense),
        .tm_src_i   ({3'b000, srcv[6]}),
        .tm2_src_i  ({3'b000, srcv[7]}),
        .tb0_src_i  (srcv[0]),
        .tb1_src_i  (srcv[1]),
        .ee_src_i   (srcv[5]),
        .adc_src_i  (srcv[2]),
        .uart_src_i (srcv[3]),
        .sim_src_i  (srcv[4]),
        .irq_ack_i  (ack),
        .rdata_o    (rdata),
        .irq_req_o  (irq_req),
        .suspend_o  (suspend),
        .sleep_o    (sleep),
        .idle_o     (idle)
    );
    smic_core_model core (
        .sys_clk_i (sys_clk),
        .reset_n_i (reset_n),
        .irq_req_i (irq_req),
        .delay_i   (dly),
        .irq_ack_o (ack)
    );
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string nm, input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        bus.addr <= a; bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 check($sformatf("reg %h", a), rdata, e);
    endtask : rd_chk
    task automatic bit_chk(input string nm, input logic s, e);
        check(nm, {7'h00, s}, {7'h00, e});
    endtask : bit_chk
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    // ------------------------------------------------------------------
    // Clock and timeout
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // The run needs about 4600 cycles; the ceiling leaves ample margin.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        bus = '0; sense = '0; srcv = 8'h00; reset_n = 1'b0;
        dly = 4'h2; failures = 0; n_tests = 0;
        rows = '{'{4'h1, 8'hFF, 8'hFF}, '{4'h1, 8'h5A, 8'h5A},
                 '{4'h2, 8'hFE, 8'h7E}, '{4'h3, 8'hF0, 8'hF0},
                 '{4'h4, 8'h0F, 8'h0F}, '{4'h5, 8'hFF, 8'h33},
                 '{4'h0, 8'hFF, 8'h17}, '{4'h6, 8'hA5, 8'hA5},
                 '{4'h7, 8'h5A, 8'h5A}, '{4'h9, 8'hFF, 8'h00},
                 '{4'h8, 8'h00, 8'h00}};
        srcs = '{'{4'h4, 8'h20, 8'h0}, '{4'h4, 8'h40, 8'h0},
                 '{4'h4, 8'h80, 8'h0}, '{4'h3, 8'h40, 8'h0},
                 '{4'h3, 8'h20, 8'h0}, '{4'h5, 8'h20, 8'h0},
                 '{4'h2, 8'h40, 8'h6}, '{4'h3, 8'h10, 8'h7}};
        pins = '{'{4'h2, 8'h10, 8'h0}, '{4'h2, 8'h20, 8'h0},
                 '{4'h3, 8'h80, 8'h0}, '{4'h4, 8'h10, 8'h0}};
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        $display("Test registers done");
        // Second reset in mid-run clears every register and output.
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 bit_chk("irq_req", irq_req, 1'b0);
        bit_chk("idle", idle, 1'b0);
        reset_n <= 1'b1;
        for (int a = 0; a < 9; a++) begin
            rd_chk(a[3:0], 8'h00);
        end
        $display("Test reset done");
        wr(4'h6, 8'h0F);
        wr(4'h7, 8'h0F);
        foreach (srcs[i]) begin
            @(posedge sys_clk) srcv <= 8'h01 << i;
            @(posedge sys_clk) srcv <= 8'h00;
            repeat (3) @(posedge sys_clk);
            rd_chk(srcs[i].a, srcs[i].d);
            if (srcs[i].e != 8'h0) wr(srcs[i].e[3:0], 8'h0F);
            wr(srcs[i].a, 8'h00);
        end
        $display("Test sources done");
        // every edge code on pin 0, irq forwarded.
        for (int c = 0; c < 4; c++) begin
            wr(4'h1, c[7:0]);
            wr(4'h2, 8'h03);
            @(posedge sys_clk) sense.pins[0] <= 1'b1;
            repeat (3) @(posedge sys_clk);
            #1 bit_chk("irq_req", irq_req, c[0]);
            rd_chk(4'h2, c[0] ? 8'h13 : 8'h03);
            wr(4'h2, 8'h03);
            @(posedge sys_clk) sense.pins[0] <= 1'b0;
            repeat (3) @(posedge sys_clk);
            rd_chk(4'h2, c[1] ? 8'h13 : 8'h03);
            wr(4'h2, 8'h00);
        end
        wr(4'h1, 8'h55);
        foreach (pins[p]) begin
            @(posedge sys_clk) sense.pins[p] <= 1'b1;
            repeat (3) @(posedge sys_clk);
            rd_chk(pins[p].a, pins[p].d);
            wr(pins[p].a, 8'h00);
        end
        $display("Test pins done");
        wr(4'h2, 8'h12);
        repeat (3) @(posedge sys_clk);
        #1 bit_chk("irq_req", irq_req, 1'b0);
        wr(4'h2, 8'h13);
        repeat (8) @(posedge sys_clk);
        #1 bit_chk("irq_req", irq_req, 1'b1);
        bit_chk("suspend", suspend, 1'b1);
        wr(4'h2, 8'h03);
        repeat (4) @(posedge sys_clk);
        #1 bit_chk("suspend", suspend, 1'b0);
        wr(4'h2, 8'h00);
        $display("Test gating done");
        // low supply, delayed request, idle wake-up.
        wr(4'h8, 8'h02);
        sense.below <= 7'h01;
        wr(4'h0, 8'h10);
        // settle wait before trusting the flag.
        repeat (4) @(posedge sys_clk);
        rd_chk(4'h0, 8'h30);
        bit_chk("idle", idle, 1'b1);
        repeat (1880) @(posedge sys_clk);
        rd_chk(4'h5, 8'h00);
        repeat (200) @(posedge sys_clk);
        rd_chk(4'h5, 8'h10);
        bit_chk("idle", idle, 1'b0);
        // sleep freezes the flag although the supply recovered.
        wr(4'h8, 8'h01);
        sense.below <= 7'h00;
        repeat (5) @(posedge sys_clk);
        #1 bit_chk("sleep", sleep, 1'b1);
        rd_chk(4'h0, 8'h30);
        wr(4'h8, 8'h00);
        repeat (3) @(posedge sys_clk);
        rd_chk(4'h0, 8'h10);
        // every threshold code against a fixed pattern.
        sense.below <= 7'h2A;
        for (int t = 0; t < 8; t++) begin
            wr(4'h0, 8'h10 | t[7:0]);
            repeat (3) @(posedge sys_clk);
            rd_chk(4'h0, 8'h10 | t[7:0] |
                   ((t < 7 && t[0]) ? 8'h20 : 8'h00));
        end
        $display("Test supply done");
        // a preset supply-drop flag keeps idle from being left.
        wr(4'h0, 8'h10);
        wr(4'h5, 8'h10);
        wr(4'h8, 8'h02);
        sense.below <= 7'h01;
        repeat (2100) @(posedge sys_clk);
        #1 bit_chk("idle", idle, 1'b1);
        rd_chk(4'h5, 8'h10);
        $display("Test preset done");
        test_done();
    end
endmodule : tb_supply_monitor_and_irq_control
`default_nettype wire
